// ---- hdl/cbc_command_config.v ----
`timescale 1ns/1ps
`include "cbc_consts.vh"
// Overview of operation
// - resets reload volatile copy from non-volatile
// - non-volatile function bits flip from default once
// - both copies read/written by register commands
// - blank check: failed last erase erases
// - good last erase: read, erase on zero
// - blank sector: skip erase, finish command
// - blank check only for erase commands
// - blank check off: erase unconditionally
// - wrap bit selects 256 or 512 buffer
// - param bit overlays 4 KB sectors or uniform
// - volatile param bit read-only, follows copy
// - default hybrid layout, sectors at bottom
// - block size bit ignored, 256 KB blocks
// - legacy reset byte honoured only when enabled
// - 66h then 99h resets whenever not busy
// - bits 7, 6, 2 reserved
module cbc_command_config
(
   input wire i_clk,
   input wire i_srst,
   input wire i_hw_reset,
   input wire i_cmd_valid,
   input wire [7:0] i_cmd_code,
   input wire i_reg_sel,
   input wire [7:0] i_wr_data,
   input wire [8:0] i_load_addr,
   input wire i_sector_erase_ok,
   input wire i_blank_done,
   input wire i_blank_zero_found,
   input wire i_erase_done,
   output reg [7:0] o_rd_data,
   output reg o_rd_valid,
   output reg o_sw_reset,
   output reg o_status_req,
   output reg o_blank_start,
   output reg o_erase_start,
   output reg o_erase_skipped,
   output reg o_cmd_done,
   output reg o_busy,
   output reg [8:0] o_buf_addr,
   output reg o_buffer_wrap_select,
   output reg o_param_sector_disable,
   output reg o_param_sector_location_boot,
   output reg o_blank_check_enable,
   output reg o_legacy_reset_enable
);
   wire [7:0] nv_value;
   reg [7:0] vol_ff;
   reg [7:0] nxt_vol;
   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg reset_armed_ff;
   reg nxt_reset_armed;
   reg nxt_status_req;
   reg nxt_blank_start;
   reg nxt_erase_start;
   reg nxt_erase_skipped;
   reg nxt_cmd_done;
   reg nxt_busy;
   reg nxt_rd_valid;
   reg [7:0] nxt_rd_data;
   reg [8:0] wrap_mask;
   reg [8:0] nxt_buf_addr;
   wire is_erase;
   wire is_wr;
   wire soft_reset;
   wire reload;
   wire nv_prog;

   // block size bit is stored only; erase size never depends on it
   assign is_erase = (i_cmd_code == `CBC_CMD_PARAM_ERASE) ||
      (i_cmd_code == `CBC_CMD_PARAM_ERASE4) ||
      (i_cmd_code == `CBC_CMD_SECTOR_ERASE) ||
      (i_cmd_code == `CBC_CMD_SECTOR_ERASE4) ||
      (i_cmd_code == `CBC_CMD_BULK_ERASE) ||
      (i_cmd_code == `CBC_CMD_BULK_ERASE2);
   assign is_wr = i_cmd_valid && (i_cmd_code == `CBC_CMD_WRITE_ANY);
   assign nv_prog = is_wr && (i_reg_sel == `CBC_REG_NONVOLATILE) && !o_busy;
   assign soft_reset = i_cmd_valid && !o_busy &&
      (((i_cmd_code == `CBC_CMD_LEGACY_RESET) && vol_ff[`CBC_BIT_LEGACY_RESET]) ||
      ((i_cmd_code == `CBC_CMD_RESET) && reset_armed_ff));
   assign reload = i_srst || i_hw_reset || soft_reset;

   cbc_otp_store u_otp
   (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_prog(nv_prog),
      .i_data(i_wr_data),
      .o_value(nv_value)
   );

   // volatile next value
   always @*
   begin
      nxt_vol = vol_ff;
      if (reload)
         nxt_vol = nv_value;
      else if (is_wr && (i_reg_sel == `CBC_REG_VOLATILE) && !o_busy)
      begin
         nxt_vol = i_wr_data & `CBC_FUNC_MASK;
      end
      // parameter bit is read-only and tracks the non-volatile copy
      if (!reload)
         nxt_vol[`CBC_BIT_PARAM_DISABLE] = nv_value[`CBC_BIT_PARAM_DISABLE];
   end

   // erase sequencer
   always @*
   begin
      nxt_state = state_ff;
      case (state_ff)
         `CBC_ST_IDLE:
         begin
            if (i_cmd_valid && is_erase && !reload)
            begin
               if (vol_ff[`CBC_BIT_BLANK_CHECK])
                  nxt_state = `CBC_ST_STATUS;
               else
                  nxt_state = `CBC_ST_ERASE;
            end
         end
         `CBC_ST_STATUS:
         begin
            if (i_sector_erase_ok)
               nxt_state = `CBC_ST_BLANK;
            else
               nxt_state = `CBC_ST_ERASE;
         end
         `CBC_ST_BLANK:
         begin
            if (i_blank_zero_found)
               nxt_state = `CBC_ST_ERASE;
            else if (i_blank_done)
               nxt_state = `CBC_ST_DONE;
         end
         `CBC_ST_ERASE:
         begin
            if (i_erase_done)
               nxt_state = `CBC_ST_DONE;
         end
         `CBC_ST_DONE:
            nxt_state = `CBC_ST_IDLE;
         default:
            nxt_state = `CBC_ST_IDLE;
      endcase
   end

   // sequencer pulses, registered below so each output comes from a flop
   always @*
   begin
      nxt_status_req = 1'b0;
      nxt_blank_start = 1'b0;
      nxt_erase_start = 1'b0;
      nxt_erase_skipped = 1'b0;
      nxt_cmd_done = 1'b0;
      nxt_busy = 1'b0;
      if ((state_ff == `CBC_ST_IDLE) && (nxt_state == `CBC_ST_STATUS))
         nxt_status_req = 1'b1;
      if ((state_ff == `CBC_ST_STATUS) && (nxt_state == `CBC_ST_BLANK))
         nxt_blank_start = 1'b1;
      if ((state_ff != `CBC_ST_ERASE) && (nxt_state == `CBC_ST_ERASE))
         nxt_erase_start = 1'b1;
      if ((state_ff == `CBC_ST_BLANK) && (nxt_state == `CBC_ST_DONE))
         nxt_erase_skipped = 1'b1;
      if (nxt_state == `CBC_ST_DONE)
         nxt_cmd_done = 1'b1;
      // busy covers every state but idle and done
      if ((nxt_state != `CBC_ST_IDLE) && (nxt_state != `CBC_ST_DONE))
         nxt_busy = 1'b1;
   end

   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         state_ff <= `CBC_ST_IDLE;
         o_status_req <= 1'b0;
         o_blank_start <= 1'b0;
         o_erase_start <= 1'b0;
         o_erase_skipped <= 1'b0;
         o_cmd_done <= 1'b0;
         o_busy <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         o_status_req <= nxt_status_req;
         o_blank_start <= nxt_blank_start;
         o_erase_start <= nxt_erase_start;
         o_erase_skipped <= nxt_erase_skipped;
         o_cmd_done <= nxt_cmd_done;
         o_busy <= nxt_busy;
      end
   end

   // read path: answer one cycle after the read command
   always @*
   begin
      nxt_rd_valid = i_cmd_valid && (i_cmd_code == `CBC_CMD_READ_ANY);
      nxt_rd_data = o_rd_data;
      if (nxt_rd_valid)
      begin
         if (i_reg_sel == `CBC_REG_VOLATILE)
            nxt_rd_data = vol_ff & `CBC_FUNC_MASK;
         else
            nxt_rd_data = nv_value & `CBC_FUNC_MASK;
      end
   end

   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_rd_valid <= 1'b0;
         o_rd_data <= 8'h00;
      end
      else
      begin
         o_rd_valid <= nxt_rd_valid;
         o_rd_data <= nxt_rd_data;
      end
   end

   // two-step reset: the arm flag only survives one accepted command
   always @*
   begin
      nxt_reset_armed = reset_armed_ff;
      if (i_cmd_valid && !o_busy)
         nxt_reset_armed = (i_cmd_code == `CBC_CMD_RESET_ENABLE);
   end

   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         reset_armed_ff <= 1'b0;
         o_sw_reset <= 1'b0;
      end
      else
      begin
         reset_armed_ff <= nxt_reset_armed;
         o_sw_reset <= soft_reset;
      end
   end

   // page buffer load address wraps at 256 or 512 bytes
   always @*
   begin
      if (vol_ff[`CBC_BIT_BUFFER_WRAP])
         wrap_mask = `CBC_WRAP_512;
      else
         wrap_mask = `CBC_WRAP_256;
      nxt_buf_addr = i_load_addr & wrap_mask;
   end

   always @(posedge i_clk)
   begin
      if (i_srst)
         o_buf_addr <= 9'h000;
      else
         o_buf_addr <= nxt_buf_addr;
   end

   // volatile copy; new value serves the next decoded command
   always @(posedge i_clk)
   begin
      if (i_srst)
         vol_ff <= nv_value;
      else
         vol_ff <= nxt_vol;
   end

   // mirrors of the volatile controls for the array logic; boot location held at 0 (bottom)
   always @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_buffer_wrap_select <= 1'b0;
         o_param_sector_disable <= 1'b0;
         o_param_sector_location_boot <= 1'b0;
         o_blank_check_enable <= 1'b0;
         o_legacy_reset_enable <= 1'b0;
      end
      else
      begin
         o_buffer_wrap_select <= vol_ff[`CBC_BIT_BUFFER_WRAP];
         o_param_sector_disable <= vol_ff[`CBC_BIT_PARAM_DISABLE];
         o_param_sector_location_boot <= 1'b0;
         o_blank_check_enable <= vol_ff[`CBC_BIT_BLANK_CHECK];
         o_legacy_reset_enable <= vol_ff[`CBC_BIT_LEGACY_RESET];
      end
   end
endmodule

// ---- hdl/cbc_consts.vh ----
`ifndef CBC_CONSTS_VH
`define CBC_CONSTS_VH
// register identifiers on the register command port
`define CBC_REG_NONVOLATILE 1'b0
`define CBC_REG_VOLATILE 1'b1
// field positions
`define CBC_BIT_BLANK_CHECK 5
`define CBC_BIT_BUFFER_WRAP 4
`define CBC_BIT_PARAM_DISABLE 3
`define CBC_BIT_BLOCK_SIZE 1
`define CBC_BIT_LEGACY_RESET 0
// bits with a function; 7, 6 and 2 are reserved
`define CBC_FUNC_MASK 8'h3b
// factory default of the non-volatile copy
`define CBC_NV_DEFAULT 8'h02
// instruction codes
`define CBC_CMD_READ_ANY 8'h65
`define CBC_CMD_WRITE_ANY 8'h71
`define CBC_CMD_PARAM_ERASE 8'h20
`define CBC_CMD_PARAM_ERASE4 8'h21
`define CBC_CMD_SECTOR_ERASE 8'hd8
`define CBC_CMD_SECTOR_ERASE4 8'hdc
`define CBC_CMD_BULK_ERASE 8'h60
`define CBC_CMD_BULK_ERASE2 8'hc7
`define CBC_CMD_LEGACY_RESET 8'hf0
`define CBC_CMD_RESET_ENABLE 8'h66
`define CBC_CMD_RESET 8'h99
// page buffer wrap masks
`define CBC_WRAP_256 9'h0ff
`define CBC_WRAP_512 9'h1ff
// erase sequencer states
`define CBC_ST_IDLE 3'h0
`define CBC_ST_STATUS 3'h1
`define CBC_ST_BLANK 3'h2
`define CBC_ST_ERASE 3'h3
`define CBC_ST_DONE 3'h4
`endif

// ---- hdl/cbc_otp_store.v ----
`timescale 1ns/1ps
`include "cbc_consts.vh"
// one-time programmable copy: each function bit may leave its default once
module cbc_otp_store
(
   input wire i_clk,
   input wire i_srst,
   input wire i_prog,
   input wire [7:0] i_data,
   output wire [7:0] o_value
);
   localparam [7:0] FUNC_MASK = `CBC_FUNC_MASK;
   localparam [7:0] NV_DEFAULT = `CBC_NV_DEFAULT;
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_bit
         reg used_ff;
         reg val_ff;
         wire want_flip;
         assign want_flip = i_prog && FUNC_MASK[g]
            && (i_data[g] != NV_DEFAULT[g]) && !used_ff;
         // a programmed bit stays programmed across every reset
         always @(posedge i_clk)
         begin
            if (want_flip)
            begin
               used_ff <= 1'b1;
               val_ff <= ~NV_DEFAULT[g];
            end
            else if (used_ff !== 1'b1)
            begin
               used_ff <= 1'b0;
               val_ff <= NV_DEFAULT[g];
            end
         end
         assign o_value[g] = val_ff & FUNC_MASK[g];
      end
   endgenerate
endmodule

// ---- testbench/cbc_config_properties.sv ----
`timescale 1ns/1ps
module cbc_config_properties
(
   input logic i_clk, i_srst, i_cmd_valid, i_sector_erase_ok, i_blank_zero_found,
   input logic [7:0] i_cmd_code,
   input logic [7:0] o_rd_data,
   input logic o_rd_valid, o_sw_reset, o_status_req, o_blank_start, o_erase_start,
   input logic o_erase_skipped, o_cmd_done, o_busy, o_param_sector_location_boot
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   a_read_answer: assert property (i_cmd_valid && i_cmd_code == 8'h65 |=> o_rd_valid)
      else $error("read not answered");
   a_reserved_read_zero: assert property (o_rd_valid |-> (o_rd_data & 8'hc4) == 8'h00)
      else $error("reserved bits not zero");
   a_status_bad_erase: assert property (o_status_req && !i_sector_erase_ok |=> o_erase_start)
      else $error("failed sector not erased");
   a_status_good_blank: assert property (o_status_req && i_sector_erase_ok |=> o_blank_start)
      else $error("blank read not started");
   a_zero_erase: assert property (o_busy && i_blank_zero_found |=> o_erase_start)
      else $error("zero found but no erase");
   a_skip_done: assert property (o_erase_skipped |-> o_cmd_done && !o_erase_start)
      else $error("skip without finish");
   a_layout_bottom: assert property (o_param_sector_location_boot == 1'b0)
      else $error("sector layout not bottom");
   a_reset_cause: assert property (o_sw_reset |-> $past(i_cmd_valid)
      && ($past(i_cmd_code) == 8'hf0 || $past(i_cmd_code) == 8'h99))
      else $error("reset without reset command");
   c_skip: cover property (o_erase_skipped);
   c_reset: cover property (o_sw_reset);
   c_blank: cover property (o_blank_start);
endmodule
bind cbc_command_config cbc_config_properties u_props (.*);

// ---- testbench/cbc_array_model.sv ----
`timescale 1ns/1ps
// array side: answers blank reads and erases after DLY cycles
module cbc_array_model #(parameter int DLY = 3)
(
   input wire logic i_clk,
   input wire logic i_blank_start,
   input wire logic i_erase_start,
   input wire logic i_zero,
   output logic o_blank_done,
   output logic o_zero_found,
   output logic o_erase_done
);
   int cnt = 0;
   logic kind = 0;
   initial {o_blank_done, o_zero_found, o_erase_done} = 3'b000;
   always @(posedge i_clk)
   begin
      {o_blank_done, o_zero_found, o_erase_done} <= 3'b000;
      cnt <= (i_blank_start || i_erase_start) ? DLY : (cnt > 0 ? cnt - 1 : 0);
      if (i_blank_start || i_erase_start)
         kind <= i_erase_start;
      else if (cnt == 1)
         {o_erase_done, o_zero_found, o_blank_done} <= {kind, !kind && i_zero,
            !kind && !i_zero};
   end
endmodule

// ---- testbench/tb_command_behavior_config_reg.sv ----
`timescale 1ns/1ps
module tb_command_behavior_config_reg;
   logic i_clk = 0, i_srst = 1, i_hw_reset = 0, i_cmd_valid = 0, i_reg_sel = 0;
   logic i_sector_erase_ok = 0, zero = 0;
   logic [7:0] i_cmd_code = 0, i_wr_data = 0;
   logic [8:0] i_load_addr = 0;
   wire i_blank_done, i_blank_zero_found, i_erase_done;
   wire [7:0] o_rd_data;
   wire [8:0] o_buf_addr;
   wire o_rd_valid, o_sw_reset, o_status_req, o_blank_start, o_erase_start, o_erase_skipped;
   wire o_cmd_done, o_busy, o_buffer_wrap_select, o_param_sector_disable;
   wire o_param_sector_location_boot, o_blank_check_enable, o_legacy_reset_enable;
   int errors = 0, comparisons = 0;
   logic [7:0] ec [6] = '{8'h20, 8'h21, 8'hd8, 8'hdc, 8'h60, 8'hc7};
   cbc_command_config DUT (.*);
   cbc_array_model #(.DLY(4)) u_array (.i_clk(i_clk), .i_blank_start(o_blank_start),
      .i_erase_start(o_erase_start), .i_zero(zero), .o_blank_done(i_blank_done),
      .o_zero_found(i_blank_zero_found), .o_erase_done(i_erase_done));
   initial forever #10 i_clk = ~i_clk;
   task finish_test;
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [9:0] got, input logic [9:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task cmd(input logic [7:0] c, input logic s, input logic [7:0] d);
      @(posedge i_clk);
      {i_cmd_valid, i_cmd_code, i_reg_sel, i_wr_data} <= {1'b1, c, s, d};
      @(posedge i_clk);
      i_cmd_valid <= 0;
   endtask
   task rd(input logic s, input logic [7:0] e);
      cmd(8'h65, s, 8'h00);
      @(posedge i_clk);
      chk({o_rd_valid, o_rd_data}, {1'b1, e});
   endtask
   task sw(input logic [7:0] c, input logic e);
      cmd(c, 0, 8'h00);
      @(posedge i_clk);
      chk(o_sw_reset, e);
   endtask
   task wrap(input logic [7:0] v, input logic [8:0] e);
      cmd(8'h71, 1, v);
      i_load_addr <= 9'h1a5;
      repeat (3) @(posedge i_clk);
      chk(o_buf_addr, e);
   endtask
   task er(input logic [7:0] c, input logic ok, input logic z, input logic bc);
      int n;
      logic st, sk, sr;
      {st, sk, sr} = 3'b000;
      i_sector_erase_ok <= ok;
      zero <= z;
      cmd(c, 0, 8'h00);
      for (n = 0; n < 40 && !((st || sk) && !o_busy); n++)
      begin
         @(posedge i_clk);
         {st, sk, sr} = {st | o_erase_start, sk | o_erase_skipped, sr | o_status_req};
      end
      if (n == 40)
      begin
         errors++;
         finish_test();
      end
      chk({sr, st, sk}, {bc, !bc || !ok || z, bc && ok && !z});
   endtask
   initial
   begin
      repeat (16) @(posedge i_clk);
      i_srst <= 0;
      rd(0, 8'h02);
      rd(1, 8'h02);
      chk(o_param_sector_location_boot, 0);
      cmd(8'h71, 1, 8'hff);
      rd(1, 8'h33);
      chk({o_buffer_wrap_select, o_param_sector_disable, o_blank_check_enable,
         o_legacy_reset_enable}, 4'hb);
      @(posedge i_clk);
      i_hw_reset <= 1;
      @(posedge i_clk);
      i_hw_reset <= 0;
      rd(1, 8'h02);
      wrap(8'h00, 9'h0a5);
      wrap(8'h10, 9'h1a5);
      er(8'hd8, 1, 0, 0);
      cmd(8'h71, 1, 8'h20);
      foreach (ec[k])
         er(ec[k], k[0], k[1], 1);
      cmd(8'h71, 1, 8'h01);
      sw(8'hf0, 1);
      rd(1, 8'h02);
      sw(8'hf0, 0);
      cmd(8'h66, 0, 8'h00);
      sw(8'h99, 1);
      cmd(8'h71, 0, 8'h23);
      rd(0, 8'h23);
      cmd(8'h71, 0, 8'h02);
      rd(0, 8'h23);
      cmd(8'h71, 1, 8'h08);
      rd(1, 8'h00);
      finish_test();
   end
endmodule
